// [rtl/edpr_ctrl.sv]
`timescale 1ns/1ps
`include "edpr_consts.svh"

// Function
// - Sequential beat addresses step by four bytes
// - Separate column cycle for every beat
// - Row strobe held; whole access one page
// - Memory request decoded, access request raised
// - Access request: row strobe with row address
// - Column select drives column address after row
// - All four column strobes on reads
// - Column strobes low one cycle per beat
// - Acknowledge pulsed per completed column access
// - Request held while CPU request stays asserted
// - Wait negated exactly one cycle per beat
// - Next address gets new column strobe
// - Ack with request gone drops access request
// - Main machine idles after final wait negation
// - Precharge state; new requests taken meanwhile wait for it to end
// - Four-beat read within 356.25 ns
module edpr_ctrl
   import edpr_pkg::*;
#(
   parameter int BANKS    = `EDPR_BANKS,
   parameter int DATA_CYC = `EDPR_DATA_CYC,
   parameter int TRP_CYC  = `EDPR_TRP_CYC
)
(
   input  wire logic                        clk_sys,
   input  wire logic                        nrst,
   input  wire logic                        cpu_mreq_n,
   input  wire logic                        cpu_write,
   input  wire logic [`EDPR_ADDR_W-1:0]     cpu_addr,
   output logic                             cpu_wait_n,
   output logic                             buf_rd_oe_n,
   output logic      [BANKS-1:0]            dram_ras_n,
   output logic      [`EDPR_CAS_LANES-1:0]  dram_cas_n,
   output logic                             dram_sel_col,
   output logic      [`EDPR_MUX_W-1:0]      dram_mux_a,
   output logic                             page_err,
   output logic                             seq_slow
);

   edpr_main_st_t                 main_r;
   edpr_main_st_t                 main_nxt;
   logic                          take;
   logic                          do_dram_r;
   logic                          last_r;
   logic                          next_beat_r;
   logic                          dram_ack;
   logic                          sel_col_nxt;
   logic [`EDPR_CNT_W-1:0]        data_cnt_r;
   logic [`EDPR_CNT_W-1:0]        seq_cnt_r;
   logic [`EDPR_CNT_W-1:0]        beat_cnt_r;
   logic [`EDPR_ADDR_W-1:0]       prev_addr_r;
   logic [`EDPR_ROW_W-1:0]        row_r;
   logic [`EDPR_BANK_W-1:0]       bank_r;
   logic                          wait_n_r;
   logic                          oe_n_r;
   logic                          page_err_r;
   logic                          seq_slow_r;

   // Only memory reads are served here
   assign take = (main_r == M_IDLE) && !cpu_mreq_n && !cpu_write &&
                 edpr_is_dram(cpu_addr);

   always_comb
   begin
      main_nxt = main_r;
      case (main_r)
         M_IDLE: if (take) main_nxt = M_ACK;
         M_ACK:  if (dram_ack) main_nxt = M_DATA;
         M_DATA: if (data_cnt_r == '0) main_nxt = M_WAIT;
         M_WAIT: main_nxt = last_r ? M_IDLE : M_ACK;
         default: main_nxt = M_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         main_r <= M_IDLE;
      else
         main_r <= main_nxt;
   end

   // Access request to the DRAM machine
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         do_dram_r <= 1'b0;
      else if (take)
         do_dram_r <= 1'b1;
      else if (main_r == M_ACK && dram_ack && cpu_mreq_n)
         do_dram_r <= 1'b0;
   end

   // Final beat known once ack sees the request gone
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         last_r <= 1'b0;
      else if (take)
         last_r <= 1'b0;
      else if (main_r == M_ACK && dram_ack)
         last_r <= cpu_mreq_n;
   end

   // Next column cycle once the CPU shows the next address
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         next_beat_r <= 1'b0;
      else
         next_beat_r <= (main_r == M_WAIT) && !last_r;
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         data_cnt_r <= '0;
      else if (main_r == M_ACK && dram_ack)
         data_cnt_r <= `EDPR_CNT_W'(DATA_CYC - 1);
      else if (main_r == M_DATA && data_cnt_r != '0)
         data_cnt_r <= data_cnt_r - 1'b1;
   end

   // Wait low during access, high one cycle per beat
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         wait_n_r <= 1'b1;
      else
         wait_n_r <= (main_nxt == M_WAIT) || (main_nxt == M_IDLE);
   end

   // Read buffers drive the CPU bus while data is returned
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         oe_n_r <= 1'b1;
      else
         oe_n_r <= !((main_nxt == M_DATA) || (main_nxt == M_WAIT));
   end

   // Page and step check on each following beat
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         prev_addr_r <= '0;
      else if (take || next_beat_r)
         prev_addr_r <= cpu_addr;
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         page_err_r <= 1'b0;
      else if (take)
         page_err_r <= 1'b0;
      else if (next_beat_r &&
               (edpr_row_of(cpu_addr) != row_r ||
                edpr_bank_of(cpu_addr) != bank_r ||
                cpu_addr != prev_addr_r + `EDPR_WORD_STEP))
         page_err_r <= 1'b1;
   end

   // Cycle and beat count of one access
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         seq_cnt_r  <= '0;
         beat_cnt_r <= '0;
      end
      else if (take)
      begin
         seq_cnt_r  <= `EDPR_CNT_W'(1);
         beat_cnt_r <= '0;
      end
      else if (main_r != M_IDLE)
      begin
         if (seq_cnt_r != '1)
            seq_cnt_r <= seq_cnt_r + 1'b1;
         if (main_r == M_WAIT)
            beat_cnt_r <= beat_cnt_r + 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         seq_slow_r <= 1'b0;
      else if (take)
         seq_slow_r <= 1'b0;
      else if (main_r == M_WAIT && last_r &&
               beat_cnt_r == `EDPR_CNT_W'(`EDPR_SEQ4_BEATS - 1) &&
               seq_cnt_r > `EDPR_CNT_W'(`EDPR_SEQ4_CYC))
         seq_slow_r <= 1'b1;
   end

   assign cpu_wait_n  = wait_n_r;
   assign buf_rd_oe_n = oe_n_r;
   assign page_err    = page_err_r;
   assign seq_slow    = seq_slow_r;

   edpr_dram_sm #(
      .BANKS   (BANKS),
      .TRP_CYC (TRP_CYC)
   ) u_dram (
      .clk_sys     (clk_sys),
      .nrst        (nrst),
      .do_dram     (do_dram_r),
      .next_beat   (next_beat_r),
      .bank        (bank_r),
      .ras_n_r     (dram_ras_n),
      .cas_n_r     (dram_cas_n),
      .sel_col_r   (dram_sel_col),
      .sel_col_nxt (sel_col_nxt),
      .ack_r       (dram_ack)
   );

   edpr_addr_mux u_mux (
      .clk_sys   (clk_sys),
      .nrst      (nrst),
      .cpu_addr  (cpu_addr),
      .latch_row (take),
      .sel_col   (sel_col_nxt),
      .mux_a_r   (dram_mux_a),
      .row_r     (row_r),
      .bank_r    (bank_r)
   );

endmodule // edpr_ctrl

// [common/edpr_consts.svh]
`ifndef EDPR_CONSTS_SVH
`define EDPR_CONSTS_SVH

// Address layout of a byte address
`define EDPR_ADDR_W       32
`define EDPR_WORD_LSB     2
`define EDPR_COL_W        10
`define EDPR_ROW_W        10
`define EDPR_BANK_W       1
`define EDPR_BANKS        2
`define EDPR_MUX_W        10
`define EDPR_REGION_W     4
`define EDPR_DRAM_REGION  4'h0
`define EDPR_WORD_STEP    32'h0000_0004
`define EDPR_CAS_LANES    4
`define EDPR_CAS_ALL_N    4'h0
`define EDPR_CAS_NONE_N   4'hf

// Timing
`define EDPR_CLK_PS       10000
`define EDPR_TRP_PS       60000
`define EDPR_TRP_CYC      ((`EDPR_TRP_PS + `EDPR_CLK_PS - 1) / `EDPR_CLK_PS)
`define EDPR_SEQ4_PS      356250
`define EDPR_SEQ4_CYC     (`EDPR_SEQ4_PS / `EDPR_CLK_PS)
`define EDPR_SEQ4_BEATS   4
`define EDPR_DATA_CYC     1
`define EDPR_CNT_W        8

`endif

// [common/edpr_pkg.sv]
`include "edpr_consts.svh"

package edpr_pkg;

   typedef enum logic [1:0] {M_IDLE, M_ACK, M_DATA, M_WAIT} edpr_main_st_t;

   typedef enum logic [2:0] {D_IDLE, D_RAS, D_COL, D_CAS, D_ACK, D_PAGE,
                             D_PRE} edpr_dram_st_t;

   function automatic logic edpr_is_dram(input logic [`EDPR_ADDR_W-1:0] a);
      return a[`EDPR_ADDR_W-1 -: `EDPR_REGION_W] == `EDPR_DRAM_REGION;
   endfunction

   function automatic logic [`EDPR_COL_W-1:0] edpr_col_of(
      input logic [`EDPR_ADDR_W-1:0] a);
      return a[`EDPR_WORD_LSB +: `EDPR_COL_W];
   endfunction

   function automatic logic [`EDPR_ROW_W-1:0] edpr_row_of(
      input logic [`EDPR_ADDR_W-1:0] a);
      return a[`EDPR_WORD_LSB + `EDPR_COL_W +: `EDPR_ROW_W];
   endfunction

   function automatic logic [`EDPR_BANK_W-1:0] edpr_bank_of(
      input logic [`EDPR_ADDR_W-1:0] a);
      return a[`EDPR_WORD_LSB + `EDPR_COL_W + `EDPR_ROW_W +: `EDPR_BANK_W];
   endfunction

endpackage

// [rtl/edpr_addr_mux.sv]
`timescale 1ns/1ps
`include "edpr_consts.svh"

module edpr_addr_mux
   import edpr_pkg::*;
(
   input  wire logic                    clk_sys,
   input  wire logic                    nrst,
   input  wire logic [`EDPR_ADDR_W-1:0] cpu_addr,
   input  wire logic                    latch_row,
   input  wire logic                    sel_col,
   output logic      [`EDPR_MUX_W-1:0]  mux_a_r,
   output logic      [`EDPR_ROW_W-1:0]  row_r,
   output logic      [`EDPR_BANK_W-1:0] bank_r
);

   // Row while the row strobe falls, column once selected
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         mux_a_r <= '0;
      else if (sel_col)
         mux_a_r <= edpr_col_of(cpu_addr);
      else
         mux_a_r <= edpr_row_of(cpu_addr);
   end

   // Page held for the whole access
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         row_r  <= '0;
         bank_r <= '0;
      end
      else if (latch_row)
      begin
         row_r  <= edpr_row_of(cpu_addr);
         bank_r <= edpr_bank_of(cpu_addr);
      end
   end

endmodule // edpr_addr_mux

// [rtl/edpr_dram_sm.sv]
`timescale 1ns/1ps
`include "edpr_consts.svh"

module edpr_dram_sm
   import edpr_pkg::*;
#(
   parameter int BANKS   = `EDPR_BANKS,
   parameter int TRP_CYC = `EDPR_TRP_CYC
)
(
   input  wire logic                        clk_sys,
   input  wire logic                        nrst,
   input  wire logic                        do_dram,
   input  wire logic                        next_beat,
   input  wire logic [`EDPR_BANK_W-1:0]     bank,
   output logic      [BANKS-1:0]            ras_n_r,
   output logic      [`EDPR_CAS_LANES-1:0]  cas_n_r,
   output logic                             sel_col_r,
   output logic                             sel_col_nxt,
   output logic                             ack_r
);

   edpr_dram_st_t               st_r;
   edpr_dram_st_t               st_nxt;
   logic [`EDPR_CNT_W-1:0]      pre_cnt_r;

   always_comb
   begin
      st_nxt = st_r;
      case (st_r)
         D_IDLE: if (do_dram) st_nxt = D_RAS;
         D_RAS:  st_nxt = D_COL;
         D_COL:  st_nxt = D_CAS;
         D_CAS:  st_nxt = D_ACK;
         D_ACK:  st_nxt = D_PAGE;
         D_PAGE:
         begin
            if (!do_dram)
               st_nxt = D_PRE;
            else if (next_beat)
               st_nxt = D_COL;
         end
         D_PRE:  if (pre_cnt_r == '0) st_nxt = D_IDLE;
         default: st_nxt = D_IDLE;
      endcase
   end

   assign sel_col_nxt = (st_nxt == D_COL) || (st_nxt == D_CAS) ||
                        (st_nxt == D_ACK) || (st_nxt == D_PAGE);

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         st_r <= D_IDLE;
      else
         st_r <= st_nxt;
   end

   // Row strobe held from row latch through every beat
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         ras_n_r <= '1;
      else if (st_nxt == D_IDLE || st_nxt == D_PRE)
         ras_n_r <= '1;
      else
         ras_n_r <= ~(BANKS'(1) << bank);
   end

   // All lanes, one cycle per beat
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         cas_n_r <= `EDPR_CAS_NONE_N;
      else if (st_nxt == D_CAS)
         cas_n_r <= `EDPR_CAS_ALL_N;
      else
         cas_n_r <= `EDPR_CAS_NONE_N;
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         sel_col_r <= 1'b0;
         ack_r     <= 1'b0;
      end
      else
      begin
         sel_col_r <= sel_col_nxt;
         ack_r     <= (st_nxt == D_ACK);
      end
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         pre_cnt_r <= '0;
      else if (st_nxt == D_PRE && st_r != D_PRE)
         pre_cnt_r <= `EDPR_CNT_W'(TRP_CYC - 1);
      else if (pre_cnt_r != '0)
         pre_cnt_r <= pre_cnt_r - 1'b1;
   end

endmodule // edpr_dram_sm

// [tb/edpr_monitor.sv]
`timescale 1ns/1ps
module edpr_monitor
#(
   parameter int BANKS   = 2,
   parameter int TRP_CYC = 6
)
(
   input wire logic             clk_sys,
   input wire logic             nrst,
   input wire logic             cpu_mreq_n,
   input wire logic             cpu_write,
   input wire logic [31:0]      cpu_addr,
   input wire logic             cpu_wait_n,
   input wire logic             buf_rd_oe_n,
   input wire logic [BANKS-1:0] dram_ras_n,
   input wire logic [3:0]       dram_cas_n,
   input wire logic             dram_sel_col
);
   logic [3:0] hi_r;
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         hi_r <= 4'hf;
      else if (!(&dram_ras_n))
         hi_r <= 4'h0;
      else if (hi_r != 4'hf)
         hi_r <= hi_r + 4'h1;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // Request taken while the row side has fully recovered
   sequence s_taken;
      !cpu_mreq_n && cpu_wait_n && !cpu_write && cpu_addr[31:28] == 4'h0
      && hi_r > TRP_CYC + 1;
   endsequence
   a_cas_all_lanes:
   assert property (dram_cas_n == 4'h0 || dram_cas_n == 4'hf)
      else $error("column strobes split");
   a_cas_one_cycle:
   assert property (dram_cas_n == 4'h0 |=> (dram_cas_n == 4'hf) [*5])
      else $error("column strobe too long");
   a_wait_one_pulse:
   assert property ($rose(cpu_wait_n) && !cpu_mreq_n |=> !cpu_wait_n)
      else $error("wait release not one cycle");
   a_data_on_bus:
   assert property ($rose(cpu_wait_n) |-> !buf_rd_oe_n)
      else $error("read buffers off at data beat");
   a_ras_held:
   assert property (!cpu_mreq_n && !(&dram_ras_n) |=> $stable(dram_ras_n))
      else $error("row strobe moved mid access");
   a_row_then_col:
   assert property ($fell(&dram_ras_n) |=> $rose(dram_sel_col))
      else $error("column select late");
   a_cas_on_col:
   assert property (dram_cas_n != 4'hf |-> dram_sel_col && !(&dram_ras_n))
      else $error("column strobe without column");
   a_req_to_row:
   assert property (s_taken |-> ##2 !dram_ras_n[cpu_addr[22]])
      else $error("row strobe not raised for bank");
   a_first_beat_time:
   assert property (s_taken |=> !cpu_wait_n [*6] ##1 cpu_wait_n)
      else $error("first beat latency wrong");
   a_precharge_gap:
   assert property ($fell(&dram_ras_n) |-> hi_r >= TRP_CYC)
      else $error("row precharge too short");
   a_reset_idle:
   assert property ($rose(nrst) |-> cpu_wait_n && &dram_ras_n
                    && dram_cas_n == 4'hf && !dram_sel_col && buf_rd_oe_n)
      else $error("not idle after reset");
   cover property (s_taken);
   cover property ($rose(cpu_wait_n) && cpu_mreq_n);
   cover property ($fell(dram_ras_n[BANKS-1]));
endmodule // edpr_monitor

bind edpr_ctrl edpr_monitor #(.BANKS(BANKS), .TRP_CYC(TRP_CYC)) u_mon (
   .clk_sys, .nrst, .cpu_mreq_n, .cpu_write, .cpu_addr, .cpu_wait_n,
   .buf_rd_oe_n, .dram_ras_n, .dram_cas_n, .dram_sel_col);

// [tb/edpr_cpu_model.sv]
`timescale 1ns/1ps
module edpr_cpu_model
(
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   input  wire logic        go,
   input  wire logic [2:0]  beats,
   input  wire logic [31:0] base,
   input  wire logic        wr,
   input  wire logic        bad_step,
   input  wire logic        cpu_wait_n,
   output logic             cpu_mreq_n,
   output logic             cpu_write,
   output logic [31:0]      cpu_addr,
   output logic             busy,
   output logic [7:0]       lat
);
   logic [2:0] left;
   logic       seen;
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         cpu_mreq_n <= 1'b1;
         cpu_write  <= 1'b0;
         cpu_addr   <= 32'h0000_0000;
         busy       <= 1'b0;
         left       <= 3'h0;
         seen       <= 1'b0;
         lat        <= 8'h00;
      end
      else if (go && !busy)
      begin
         busy       <= 1'b1;
         cpu_mreq_n <= 1'b0;
         cpu_write  <= wr;
         cpu_addr   <= base;
         left       <= beats - 3'h1;
         seen       <= 1'b0;
         lat        <= 8'h00;
      end
      else if (busy)
      begin
         lat <= lat + 8'h01;
         if (!cpu_wait_n)
            seen <= 1'b1;
         if (left == 3'h0)
            cpu_mreq_n <= 1'b1;
         if (seen && cpu_wait_n)
         begin
            seen <= 1'b0;
            if (left == 3'h0)
            begin
               busy     <= 1'b0;
               cpu_addr <= ~cpu_addr;
            end
            else
            begin
               left     <= left - 3'h1;
               cpu_addr <= cpu_addr + (bad_step ? 32'h0000_0008
                                                : 32'h0000_0004);
            end
         end
      end
   end
endmodule // edpr_cpu_model

// [tb/edpr_ctrl_tb.sv]
`timescale 1ns/1ps
`define CHK(a, b) \
   begin \
      checks_done++; \
      if ((a) !== (b)) \
      begin \
         fails++; \
         $display("[ERR] %0t got %h want %h", $time, (a), (b)); \
      end \
   end
module edpr_ctrl_tb;
   logic        clk_sys = 0, nrst = 0, go = 0, wr = 0, bad = 0;
   logic [2:0]  beats = 3'h1;
   logic [31:0] base = 32'h0000_0000, cpu_addr;
   logic        cpu_mreq_n, cpu_write, cpu_wait_n, buf_rd_oe_n;
   logic        dram_sel_col, page_err, seq_slow, busy;
   logic [1:0]  dram_ras_n, ras_q = 2'b11, rasv;
   logic [3:0]  dram_cas_n, casv;
   logic [9:0]  dram_mux_a, rowv, colq[$];
   logic [7:0]  lat;
   int          fails = 0, checks_done = 0, cyc = 0;
   edpr_ctrl #(.TRP_CYC(6)) uut (.clk_sys, .nrst, .cpu_mreq_n,
      .cpu_write, .cpu_addr, .cpu_wait_n, .buf_rd_oe_n, .dram_ras_n,
      .dram_cas_n, .dram_sel_col, .dram_mux_a, .page_err, .seq_slow);
   edpr_cpu_model u_cpu (.clk_sys, .nrst, .go, .beats, .base, .wr,
      .bad_step(bad), .cpu_wait_n, .cpu_mreq_n, .cpu_write, .cpu_addr,
      .busy, .lat);
   always #5 clk_sys = ~clk_sys;
   // Log column and row seen on the mux at each strobe
   always @(posedge clk_sys)
   begin
      cyc++;
      if (dram_cas_n !== 4'hf)
      begin
         colq.push_back(dram_mux_a);
         casv = dram_cas_n;
      end
      if (&ras_q && !(&dram_ras_n))
      begin
         rowv = dram_mux_a;
         rasv = dram_ras_n;
      end
      ras_q = dram_ras_n;
      if (cyc == 3000)
      begin
         fails++;
         tally_and_finish();
      end
   end
   task tally_and_finish;
      $display("checks %0d errors %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task do_reset;
      nrst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      `CHK({cpu_wait_n, dram_ras_n, dram_cas_n}, 7'h7f)
      `CHK({dram_sel_col, page_err, seq_slow}, 3'h0)
      nrst <= 1'b1;
   endtask
   task do_read(input logic [2:0] n, input logic [31:0] a, input logic b);
      @(posedge clk_sys);
      beats <= n;
      base  <= a;
      bad   <= b;
      wr    <= 1'b0;
      go    <= 1'b1;
      colq.delete();
      @(posedge clk_sys);
      go <= 1'b0;
      @(posedge clk_sys);
      while (busy)
         @(posedge clk_sys);
   endtask
   task t_seq4;
      // Start from idle so precharge adds no cycles
      repeat (8) @(posedge clk_sys);
      do_read(3'h4, 32'h0000_0008, 1'b0);
      `CHK(lat, 8'd26)
      `CHK(colq.size(), 4)
      foreach (colq[i])
         `CHK(colq[i], 10'(i + 2))
      `CHK(casv, 4'h0)
      `CHK({page_err, seq_slow, buf_rd_oe_n}, 3'h1)
      `CHK({cpu_wait_n, dram_ras_n}, 3'h7)
   endtask
   task t_bank1;
      repeat (8) @(posedge clk_sys);
      do_read(3'h1, 32'h0040_3010, 1'b0);
      `CHK(rasv, 2'b01)
      `CHK(rowv, 10'h003)
      `CHK(colq[0], 10'h004)
      `CHK(lat, 8'd8)
   endtask
   task t_page;
      do_read(3'h3, 32'h0000_0040, 1'b1);
      `CHK(page_err, 1'b1)
   endtask
   task t_b2b;
      do_read(3'h4, 32'h0000_0100, 1'b0);
      do_read(3'h2, 32'h0000_0200, 1'b0);
      `CHK(lat > 8'd14, 1'b1)
      `CHK(colq.size(), 2)
      `CHK(colq[1], 10'h081)
   endtask
   task t_ignore(input logic w, input logic [31:0] a);
      @(posedge clk_sys);
      wr   <= w;
      base <= a;
      go   <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      repeat (12) @(posedge clk_sys);
      `CHK({cpu_wait_n, dram_ras_n, dram_cas_n}, 7'h7f)
      do_reset();
   endtask
   initial
   begin
      do_reset();
      t_page();
      t_seq4();
      t_bank1();
      t_b2b();
      t_ignore(1'b1, 32'h0000_0008);
      t_ignore(1'b0, 32'h1000_0008);
      t_seq4();
      tally_and_finish();
   end
endmodule // edpr_ctrl_tb
